// ---- common/pcs_fabric_pkg.sv ----
package pcs_fabric_pkg;

  // ****************************************
  // Data path layout
  // ****************************************
  localparam int BYTE_W       = 8;
  localparam int WORD_W       = 2 * BYTE_W;
  localparam int LO_BYTE_LSB  = 0;
  localparam int HI_BYTE_LSB  = BYTE_W;
  localparam int FIFO_ADDR_W  = 3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS    = 40;
  localparam int TX_PAR_PERIOD_NS = 320;
  // Half period of the transmit parallel clock, in system cycles
  localparam int TX_HALF_CYC = (TX_PAR_PERIOD_NS / CLK_PERIOD_NS) / 2;

  // ****************************************
  // Synchroniser vector field positions
  // ****************************************
  localparam int SY_REC_CLK = 0;
  localparam int SY_TXC_CLK = 1;
  localparam int SY_RXC_CLK = 2;
  localparam int SY_BO_ENA  = 3;
  localparam int SY_BO_MAN  = 4;
  localparam int SY_WIDE    = 5;
  localparam int SY_REV_ENA = 6;
  localparam int SY_RX_DATA = 7;
  localparam int SY_TX_DATA = SY_RX_DATA + WORD_W;
  localparam int SY_W       = SY_TX_DATA + WORD_W;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  // Byte ordering sequencer
  typedef enum logic [1:0] {
    BO_IDLE     = 2'b01,
    BO_WAIT_LOW = 2'b10
  } bo_state_e;

endpackage

// ---- rtl/phase_comp_fifo.sv ----
`timescale 1ns/1ps
module phase_comp_fifo
  import pcs_fabric_pkg::*;
#(
  parameter int WIDTH  = WORD_W,
  parameter int ADDR_W = FIFO_ADDR_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic             rd_en,
  output      logic [WIDTH-1:0] rd_data,
  // Status
  output      logic             full,
  output      logic             empty
);

  localparam int DEPTH = 1 << ADDR_W;

  logic [WIDTH-1:0]  mem [DEPTH];
  logic [ADDR_W-1:0] wr_ptr;
  logic [ADDR_W-1:0] rd_ptr;
  logic [ADDR_W:0]   count;
  logic [ADDR_W-1:0] next_wr_ptr;
  logic [ADDR_W-1:0] next_rd_ptr;
  logic [ADDR_W:0]   next_count;
  logic              do_wr;
  logic              do_rd;

  // Writes into a full FIFO are dropped unless a read happens in the same cycle; reads from an empty one are dropped
  assign full    = (count == (ADDR_W + 1)'(DEPTH));
  assign empty   = (count == '0);
  assign rd_data = mem[rd_ptr];
  assign do_wr   = wr_en && (!full || rd_en);
  assign do_rd   = rd_en && !empty;

  // Pointer and fill level update
  always_comb begin
    next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count;
    if (do_wr && !do_rd) begin
      next_count = count + 1'b1;
    end else if (do_rd && !do_wr) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage has no reset; contents are only read once written
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

endmodule

// ---- rtl/pcs_fabric_port.sv ----
`timescale 1ns/1ps
module pcs_fabric_port
  import pcs_fabric_pkg::*;
#(
  parameter int TX_HALF = TX_HALF_CYC
) (
  // System clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Clocks from line and fabric
  input  wire logic              rx_rec_clk,
  input  wire logic              tx_core_clk,
  input  wire logic              rx_core_clk,
  output      logic              tx_par_clk,
  output      logic              rx_par_clk,
  // Data paths
  input  wire logic [WORD_W-1:0] rx_line_data,
  output      logic [WORD_W-1:0] rx_data,
  input  wire logic [WORD_W-1:0] tx_data,
  output      logic [WORD_W-1:0] tx_line_data,
  // Phase compensation FIFO status
  output      logic              rx_fifo_full,
  output      logic              rx_fifo_empty,
  output      logic              tx_fifo_full,
  output      logic              tx_fifo_empty,
  // Byte ordering and reversal
  input  wire logic              order_manual,
  input  wire logic              order_ena,
  output      logic              order_flag,
  input  wire logic              wide_width,
  input  wire logic              byte_rev_ena
);

  // ****************************************
  // Reset release and input synchronisers
  // ****************************************
  logic            rst_s1;
  logic            rst_sync_n;
  logic [SY_W-1:0] sy_in;
  logic [SY_W-1:0] sy1;
  logic [SY_W-1:0] sy2;
  logic [2:0]      clk_prev;

  // Reset deasserts cleanly on the system clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1     <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1     <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  assign sy_in = {tx_data, rx_line_data, byte_rev_ena, wide_width,
                  order_manual, order_ena, rx_core_clk, tx_core_clk,
                  rx_rec_clk};

  // Every pin input passes two flops before use
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sy1      <= '0;
      sy2      <= '0;
      clk_prev <= '0;
    end else begin
      sy1      <= sy_in;
      sy2      <= sy1;
      clk_prev <= sy2[SY_RXC_CLK:SY_REC_CLK];
    end
  end

  // ****************************************
  // Clock edge enables
  // ****************************************
  logic rec_rise;
  logic txc_rise;
  logic rxc_rise;

  assign rec_rise = sy2[SY_REC_CLK] && !clk_prev[SY_REC_CLK];
  assign txc_rise = sy2[SY_TXC_CLK] && !clk_prev[SY_TXC_CLK];
  assign rxc_rise = sy2[SY_RXC_CLK] && !clk_prev[SY_RXC_CLK];

  // ****************************************
  // Transmit parallel clock divider
  // ****************************************
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic       next_tx_par_clk;
  logic       tx_rise;

  // Free running divider; tx_rise marks its rising edge
  always_comb begin
    next_div_cnt    = div_cnt + 8'h01;
    next_tx_par_clk = tx_par_clk;
    tx_rise         = 1'b0;
    if (div_cnt == 8'(TX_HALF - 1)) begin
      next_div_cnt    = 8'h00;
      next_tx_par_clk = !tx_par_clk;
      tx_rise         = !tx_par_clk;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt    <= 8'h00;
      tx_par_clk <= 1'b0;
    end else begin
      div_cnt    <= next_div_cnt;
      tx_par_clk <= next_tx_par_clk;
    end
  end

  // ****************************************
  // Byte ordering in the recovered domain
  // ****************************************
  bo_state_e         bo_state;
  bo_state_e         next_bo_state;
  logic              order_now;
  logic              byte_shift;
  logic              next_byte_shift;
  logic              next_order_flag;
  logic [BYTE_W-1:0] prev_hi;
  logic [BYTE_W-1:0] next_prev_hi;
  logic [WORD_W-1:0] line_word;
  logic [WORD_W-1:0] ordered;
  logic [WORD_W-1:0] rx_word;
  logic              next_rx_par_clk;

  assign line_word = sy2[SY_RX_DATA +: WORD_W];

  // Enable is only looked at on recovered clock edges, since the
  // fabric keeps it up for at least one of those periods
  always_comb begin
    next_bo_state = bo_state;
    order_now     = 1'b0;
    case (bo_state)
      BO_IDLE: begin
        if (rec_rise && sy2[SY_BO_ENA] && sy2[SY_BO_MAN]) begin
          order_now     = 1'b1;
          next_bo_state = BO_WAIT_LOW;
        end
      end
      BO_WAIT_LOW: begin
        if (rec_rise && !sy2[SY_BO_ENA]) begin
          next_bo_state = BO_IDLE;
        end
      end
      default: begin
        next_bo_state = BO_IDLE;
      end
    endcase
  end

  // Ordering slips the word boundary by one byte
  always_comb begin
    next_byte_shift = byte_shift ^ order_now;
    next_prev_hi    = rec_rise ? line_word[HI_BYTE_LSB +: BYTE_W] : prev_hi;
    next_order_flag = rec_rise ? order_now : order_flag;
    next_rx_par_clk = sy2[SY_REC_CLK];
    ordered = byte_shift ? {line_word[LO_BYTE_LSB +: BYTE_W], prev_hi}
                         : line_word;
    rx_word = ordered;
    // Reversal is only honoured at the 16 or 20 bit line width
    if (sy2[SY_WIDE] && sy2[SY_REV_ENA]) begin
      rx_word = {ordered[LO_BYTE_LSB +: BYTE_W],
                 ordered[HI_BYTE_LSB +: BYTE_W]};
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bo_state   <= BO_IDLE;
      byte_shift <= 1'b0;
      prev_hi    <= BYTE_RST;
      order_flag <= 1'b0;
      rx_par_clk <= 1'b0;
    end else begin
      bo_state   <= next_bo_state;
      byte_shift <= next_byte_shift;
      prev_hi    <= next_prev_hi;
      order_flag <= next_order_flag;
      rx_par_clk <= next_rx_par_clk;
    end
  end

  // ****************************************
  // Phase compensation FIFOs
  // ****************************************
  logic [WORD_W-1:0] rx_fifo_q;
  logic [WORD_W-1:0] tx_fifo_q;
  logic              rx_full_raw;
  logic              rx_empty_raw;
  logic              tx_full_raw;
  logic              tx_empty_raw;
  logic              tx_pop;

  // Receive side: line writes, fabric core clock reads
  phase_comp_fifo #(
    .WIDTH  (WORD_W),
    .ADDR_W (FIFO_ADDR_W)
  ) u_rx_fifo (
    .clk     (clk),
    .rst_n   (rst_sync_n),
    .wr_en   (rec_rise),
    .wr_data (rx_word),
    .rd_en   (rxc_rise),
    .rd_data (rx_fifo_q),
    .full    (rx_full_raw),
    .empty   (rx_empty_raw)
  );

  // Transmit side: fabric core clock writes, line clock reads
  phase_comp_fifo #(
    .WIDTH  (WORD_W),
    .ADDR_W (FIFO_ADDR_W)
  ) u_tx_fifo (
    .clk     (clk),
    .rst_n   (rst_sync_n),
    .wr_en   (txc_rise),
    .wr_data (sy2[SY_TX_DATA +: WORD_W]),
    .rd_en   (tx_pop),
    .rd_data (tx_fifo_q),
    .full    (tx_full_raw),
    .empty   (tx_empty_raw)
  );

  assign tx_pop = tx_rise;

  // ****************************************
  // Fabric and line side output registers
  // ****************************************
  logic [WORD_W-1:0] next_rx_data;
  logic [WORD_W-1:0] next_tx_line_data;
  logic              next_rx_full;
  logic              next_rx_empty;
  logic              next_tx_full;
  logic              next_tx_empty;

  // Flags only move on their core clock edges, so fabric can
  // sample them on that clock without a synchroniser
  always_comb begin
    next_rx_data      = rx_data;
    next_rx_full      = rx_fifo_full;
    next_rx_empty     = rx_fifo_empty;
    next_tx_full      = tx_fifo_full;
    next_tx_empty     = tx_fifo_empty;
    next_tx_line_data = tx_line_data;
    if (rxc_rise) begin
      next_rx_data  = rx_empty_raw ? rx_data : rx_fifo_q;
      next_rx_full  = rx_full_raw;
      next_rx_empty = rx_empty_raw;
    end
    if (txc_rise) begin
      next_tx_full  = tx_full_raw;
      next_tx_empty = tx_empty_raw;
    end
    if (tx_rise && !tx_empty_raw) begin
      next_tx_line_data = tx_fifo_q;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_data       <= WORD_RST;
      tx_line_data  <= WORD_RST;
      rx_fifo_full  <= 1'b0;
      rx_fifo_empty <= 1'b1;
      tx_fifo_full  <= 1'b0;
      tx_fifo_empty <= 1'b1;
    end else begin
      rx_data       <= next_rx_data;
      tx_line_data  <= next_tx_line_data;
      rx_fifo_full  <= next_rx_full;
      rx_fifo_empty <= next_rx_empty;
      tx_fifo_full  <= next_tx_full;
      tx_fifo_empty <= next_tx_empty;
    end
  end

endmodule

// ---- verif/pcs_fabric_port_checker.sv ----
`timescale 1ns/1ps
module pcs_fabric_port_checker
  import pcs_fabric_pkg::*;
(
  // Clocks and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_rec_clk,
  input wire logic tx_core_clk,
  input wire logic rx_core_clk,
  input wire logic tx_par_clk,
  input wire logic rx_par_clk,
  // Status and ordering
  input wire logic rx_fifo_full,
  input wire logic rx_fifo_empty,
  input wire logic tx_fifo_full,
  input wire logic tx_fifo_empty,
  input wire logic order_manual,
  input wire logic order_ena,
  input wire logic order_flag,
  input wire logic [WORD_W-1:0] tx_line_data
);
  // ****************
  // Port properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Ordering pulse framed by recovered edges
  sequence rec_rise;
    $rose(rx_par_clk);
  endsequence
  sequence flag_span;
    order_flag [*8] ##1 !order_flag;
  endsequence

  chk_rec_delay: assert property (
    rx_par_clk == $past(rx_rec_clk, 3))
    else $error("rx_par_clk lag wrong");
  chk_tx_period: assert property (
    $rose(tx_par_clk) |-> tx_par_clk [*4] ##1 !tx_par_clk [*4])
    else $error("tx_par_clk period wrong");
  chk_tx_pop: assert property (
    $changed(tx_line_data) |-> $rose(tx_par_clk))
    else $error("tx word off parallel edge");
  chk_flag_width: assert property ($rose(order_flag) |-> flag_span)
    else $error("order_flag width wrong");
  chk_flag_align: assert property ($changed(order_flag) |-> rec_rise)
    else $error("order_flag off recovered edge");
  chk_flag_cause: assert property (
    $rose(order_flag) |-> $past(order_ena, 3) && $past(order_manual, 3))
    else $error("order_flag without request");
  // A core rise leaves the pin high at the depth 3 sample; the depth 4 sample is still low
  chk_rx_flag_sync: assert property (
    $changed({rx_fifo_full, rx_fifo_empty}) |->
    $past(rx_core_clk, 3) || $past(rx_core_clk, 4))
    else $error("rx flag off core edge");
  chk_tx_flag_sync: assert property (
    $changed({tx_fifo_full, tx_fifo_empty}) |->
    $past(tx_core_clk, 3) || $past(tx_core_clk, 4))
    else $error("tx flag off core edge");
endmodule

// ---- verif/fabric_user_model.sv ----
`timescale 1ns/1ps
module fabric_user_model
  import pcs_fabric_pkg::*;
(
  // System clock
  input  wire logic clk,
  // Fabric core clocks and word
  output logic tx_core_clk,
  output logic rx_core_clk,
  output logic [WORD_W-1:0] tx_data,
  // Ordering handshake
  output logic order_ena,
  input  wire logic order_flag,
  output logic flag_sync
);
  // ****************
  // Fabric side
  // ****************
  logic [1:0] sync;
  initial begin
    tx_core_clk = 1'b0;
    rx_core_clk = 1'b0;
    tx_data = 16'h0001;
    order_ena = 1'b0;
    sync = 2'b00;
  end
  // Flag enters fabric logic through two flops
  always @(posedge clk) sync <= {sync[0], order_flag};
  assign flag_sync = sync[1];

  // Word moves at the low phase so it is steady at each rise
  task automatic tx_run(input int n, input int h);
    repeat (n) begin
      tx_core_clk <= 1'b1;
      repeat (h) @(posedge clk);
      tx_core_clk <= 1'b0;
      tx_data <= tx_data + 16'h0001;
      repeat (h) @(posedge clk);
    end
  endtask
  task automatic rx_run(input int n, input int h);
    repeat (n) begin
      rx_core_clk <= 1'b1;
      repeat (h) @(posedge clk);
      rx_core_clk <= 1'b0;
      repeat (h) @(posedge clk);
    end
  endtask
  // Held over several recovered periods, then dropped to rearm
  task automatic order_req(input int periods);
    order_ena <= 1'b1;
    repeat (periods * 8) @(posedge clk);
    order_ena <= 1'b0;
    repeat (16) @(posedge clk);
  endtask
endmodule

// ---- verif/pcs_fabric_port_tb_top.sv ----
`timescale 1ns/1ps
module pcs_fabric_port_tb_top;
  import pcs_fabric_pkg::*;
  // ****************
  // Bench
  // ****************
  logic clk, rst_n, rx_rec_clk, order_manual, wide_width, byte_rev_ena;
  logic tx_core_clk, rx_core_clk, order_ena, order_flag, flag_sync, fs_d;
  logic tx_par_clk, rx_par_clk, rx_fifo_full, rx_fifo_empty;
  logic tx_fifo_full, tx_fifo_empty;
  logic [WORD_W-1:0] rx_line_data, rx_data, tx_data, tx_line_data;
  logic [WORD_W-1:0] last_rx, last_tx;
  logic [WORD_W-1:0] rxq[$];
  logic [WORD_W-1:0] txq[$];
  int bad_count, num_checks, flags;

  initial clk = 1'b0;
  // System clock
  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  pcs_fabric_port u_dut (
    .clk, .rst_n, .rx_rec_clk, .tx_core_clk, .rx_core_clk, .tx_par_clk,
    .rx_par_clk, .rx_line_data, .rx_data, .tx_data, .tx_line_data,
    .rx_fifo_full, .rx_fifo_empty, .tx_fifo_full, .tx_fifo_empty,
    .order_manual, .order_ena, .order_flag, .wide_width, .byte_rev_ena
  );
  fabric_user_model u_fab (
    .clk, .tx_core_clk, .rx_core_clk, .tx_data, .order_ena, .order_flag,
    .flag_sync
  );

  // Log new output words off the edge, count synced flag pulses
  always @(negedge clk) begin
    if (rx_data !== last_rx) rxq.push_back(rx_data);
    if (tx_line_data !== last_tx) txq.push_back(tx_line_data);
    if (flag_sync === 1'b1 && fs_d === 1'b0) flags++;
    last_rx = rx_data;
    last_tx = tx_line_data;
    fs_d = flag_sync;
  end

  task automatic chk(input string what, input logic [WORD_W-1:0] exp,
                     input logic [WORD_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [WORD_W-1:0] take(input logic [WORD_W-1:0] e);
    return rxq.size() ? rxq.pop_front() : ~e;
  endfunction

  // One recovered period; data changes late in the high phase
  task automatic rec_word(input logic [WORD_W-1:0] w);
    rx_line_data <= w;
    repeat (4) @(posedge clk);
    rx_rec_clk <= 1'b1;
    repeat (3) @(posedge clk);
    rx_line_data <= ~w;
    @(posedge clk);
    rx_rec_clk <= 1'b0;
  endtask
  // Line runs while the fabric asks for one ordering
  task automatic ord_phase(input logic man, input int exp);
    order_manual <= man;
    fork
      for (int i = 0; i < 12; i++) rec_word(16'hB000 + i[15:0]);
      begin
        repeat (8) @(posedge clk);
        u_fab.order_req(4);
      end
    join
    chk("flags", exp[15:0], flags[15:0]);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Bound on the whole run
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    results;
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    rx_rec_clk = 1'b0;
    order_manual = 1'b0;
    wide_width = 1'b0;
    byte_rev_ena = 1'b0;
    rx_line_data = WORD_RST;
    last_rx = WORD_RST;
    last_tx = WORD_RST;
    fs_d = 1'b0;
    repeat (2) @(posedge clk);
    chk("rx_fifo_empty", 16'h0001, WORD_W'(rx_fifo_empty));
    chk("tx_fifo_empty", 16'h0001, WORD_W'(tx_fifo_empty));
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Swap only with wide line and enable both high
    for (int k = 0; k < 3; k++) begin
      wide_width <= (k != 0);
      byte_rev_ena <= (k != 2);
      repeat (4) @(posedge clk);
      rec_word(16'h12C4);
      u_fab.rx_run(2, 4);
      chk("rx_data", (k == 1) ? 16'hC412 : 16'h12C4, take(16'h12C4));
    end
    // Flags move only on core edges
    byte_rev_ena <= 1'b0;
    for (int i = 0; i < 4; i++) rec_word(16'hA001 + i[15:0]);
    chk("rx_fifo_empty", 16'h0001, WORD_W'(rx_fifo_empty));
    u_fab.rx_run(1, 2);
    chk("rx_fifo_empty", 16'h0000, WORD_W'(rx_fifo_empty));
    u_fab.rx_run(5, 2);
    for (int i = 0; i < 4; i++) begin
      chk("rx_data", 16'hA001 + i[15:0], take(16'h0));
    end
    chk("rx_fifo_empty", 16'h0001, WORD_W'(rx_fifo_empty));
    // Transmit words leave in order, then the FIFO overfills
    u_fab.tx_run(4, 4);
    repeat (48) @(posedge clk);
    for (int i = 1; i < 5; i++) begin
      chk("tx_line_data", i[15:0], txq.size() ? txq.pop_front() : '0);
    end
    // Odd count so the last core edge lands while the FIFO is full
    u_fab.tx_run(23, 2);
    chk("tx_fifo_full", 16'h0001, WORD_W'(tx_fifo_full));
    chk("tx_fifo_empty", 16'h0000, WORD_W'(tx_fifo_empty));
    // Held enable gives one ordering, then words slip one byte
    ord_phase(1'b1, 1);
    // Twelve line words overran the receive FIFO; drain it
    u_fab.rx_run(1, 2);
    chk("rx_fifo_full", 16'h0001, WORD_W'(rx_fifo_full));
    u_fab.rx_run(9, 2);
    chk("rx_fifo_full", 16'h0000, WORD_W'(rx_fifo_full));
    rxq.delete();
    rec_word(16'h1122);
    rec_word(16'h3344);
    u_fab.rx_run(3, 2);
    chk("rx_data", 16'h4411, rxq.size() == 2 ? rxq[1] : 16'h0);
    ord_phase(1'b1, 2);
    ord_phase(1'b0, 2);
    results;
  end
endmodule

bind pcs_fabric_port pcs_fabric_port_checker u_chk (
  .clk, .rst_n, .rx_rec_clk, .tx_core_clk, .rx_core_clk, .tx_par_clk,
  .rx_par_clk, .rx_fifo_full, .rx_fifo_empty, .tx_fifo_full,
  .tx_fifo_empty, .order_manual, .order_ena, .order_flag, .tx_line_data
);
